//--- bench/swc_far_model.sv
// Subclock crystal and key switches seen from the device pins
`timescale 1ns/1ps
`include "swc_defs.svh"
module swc_far_model (
    input wire logic                   clk,
    input wire logic                   xtal_oe,
    output logic                       sub_xtal_in,
    output logic [`SWC_KEY_W-1:0]      key_n
);
    logic osc_q   = 1'b0; // Crystal waveform, near 32.768 kHz
    logic drift_q = 1'b0; // Undriven port pin, no pull resistor

    // Crystal swings only while the device drives it
    always #15259 osc_q = ~osc_q;
    // A floating pin must not look settled, so it wanders every cycle
    always @(posedge clk) drift_q <= ~drift_q;
    assign sub_xtal_in = xtal_oe ? osc_q : drift_q;

    // Switches pull to ground; released keys sit high
    initial key_n = {`SWC_KEY_W{1'b1}};

    // Press (0) or release (1) one key just after an edge
    task automatic set_key(input int idx, input logic lvl);
        @(posedge clk);
        key_n[idx] <= lvl;
    endtask : set_key
endmodule : swc_far_model

//--- bench/swc_top_asserts.sv
// Checker for the stop-mode clock and wake controller
`timescale 1ns/1ps
`include "swc_defs.svh"
module swc_top_chk
    import swc_pkg::*;
#(
    parameter int unsigned STAB_CYC = 8
) (
    input wire logic                  clk,
    input wire logic                  rst_b,
    input swc_pkg::swc_req_s          req,
    input wire logic                  stop_req,
    input wire logic                  kr_ack,
    input wire logic [`SWC_KEY_W-1:0] key_n,
    input wire logic                  sub_xtal_out,
    input wire logic                  sub_xtal_out_oe,
    input wire logic                  cpu_run,
    input wire logic                  main_clk_run,
    input wire logic                  sub_osc_run,
    input wire logic                  ls_osc_run,
    input wire logic                  key_return_irq,
    input wire logic                  watch_tick_irq
);
    // ----
    // Shadows rebuilt from the bus, since the checker sees ports only
    // ----
    logic                  cpu_sub_q;  // CPU-on-subclock bit
    logic [`SWC_KEY_W-1:0] key_en_q;   // Key enables
    logic [31:0]           hold_cnt_q; // Cycles awake with CPU held

    // Track writes and count the settle wait
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cpu_sub_q  <= `SWC_RST_CPU_SUB;
            key_en_q   <= `SWC_RST_KEY_EN;
            hold_cnt_q <= 32'h0;
        end
        else
        begin
            if (req.wr && req.addr == `SWC_OFS_CLK_CTRL)
                cpu_sub_q <= req.wdata[`SWC_BIT_CPU_SUB];
            if (req.wr && req.addr == `SWC_OFS_KEY_EN)
                key_en_q <= req.wdata[`SWC_KEY_W-1:0];
            hold_cnt_q <= (main_clk_run && !cpu_run) ? hold_cnt_q + 32'h1 : 32'h0;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    // ----
    // Properties
    // ----
    stop_refused_a : assert property (
        stop_req && cpu_run && cpu_sub_q |=> cpu_run && main_clk_run)
        else $error("stop accepted while CPU on subclock");
    stop_enter_a : assert property (
        stop_req && cpu_run && !cpu_sub_q |=> !cpu_run && !main_clk_run && $stable(sub_osc_run))
        else $error("stop entry wrong");
    gate_order_a : assert property (
        !main_clk_run |-> !cpu_run)
        else $error("CPU runs without main clock");
    key_wake_a : assert property (
        !main_clk_run ##1 $rose(key_return_irq) |-> main_clk_run)
        else $error("key interrupt did not wake");
    settle_wait_a : assert property (
        $rose(cpu_run) |-> hold_cnt_q == STAB_CYC)
        else $error("settle wait length wrong");
    irq_hold_a : assert property (
        key_return_irq && !kr_ack |=> key_return_irq)
        else $error("key interrupt dropped before ack");
    key_edge_a : assert property (
        |($past(key_n) & ~key_n & key_en_q) |-> ##2 key_return_irq)
        else $error("key fall not flagged");
    ls_halt_a : assert property (
        req.wr && req.addr == `SWC_OFS_INT_OSC |=> ls_osc_run == !$past(req.wdata[0]))
        else $error("low-speed halt bit ignored");
    pin_sel_a : assert property (
        req.wr && req.addr == `SWC_OFS_OSC_PIN |=> sub_xtal_out_oe == $past(req.wdata[0]))
        else $error("pin select ignored");
    no_tick_a : assert property (
        !sub_osc_run |=> !$rose(watch_tick_irq))
        else $error("watch tick with subclock off");
    dead_pin_a : assert property (
        !sub_osc_run |-> !sub_xtal_out_oe && !sub_xtal_out)
        else $error("crystal driven while off");

    cover property (stop_req && cpu_run && !cpu_sub_q);
    cover property (stop_req && cpu_run && cpu_sub_q);
    cover property (!main_clk_run && !sub_osc_run && !ls_osc_run);
    cover property ($rose(cpu_run));
endmodule : swc_top_chk

bind swc_top swc_top_chk #(.STAB_CYC(STAB_CYC)) chk (.clk(clk), .rst_b(rst_b), .req(req),
    .stop_req(stop_req), .kr_ack(kr_ack), .key_n(key_n), .sub_xtal_out(sub_xtal_out),
    .sub_xtal_out_oe(sub_xtal_out_oe), .cpu_run(cpu_run), .main_clk_run(main_clk_run),
    .sub_osc_run(sub_osc_run), .ls_osc_run(ls_osc_run), .key_return_irq(key_return_irq),
    .watch_tick_irq(watch_tick_irq));

//--- bench/tb.sv
// Self-checking bench for the stop-mode clock and wake controller
`timescale 1ns/1ps
`include "swc_defs.svh"
module tb;
    import swc_pkg::*;
    localparam int unsigned STAB = 8;  // Shortened settle wait
    logic                  clk = 1'b0; // 40 MHz
    logic                  rst_b = 1'b0;
    swc_req_s              req = '0;
    logic [31:0]           rdata;
    logic                  stop_req = 1'b0;
    logic                  kr_ack = 1'b0;
    logic                  wt_ack = 1'b0;
    logic                  xin, xout, xoe, cpu_run, main_run, sub_run, ls_run, kirq, wirq;
    logic [`SWC_KEY_W-1:0] key_n;
    int                    miscompares = 0;
    int                    total_checks = 0;
    int                    cycles = 0;

    always #12.5 clk = ~clk;

    swc_top #(.STAB_CYC(STAB)) dut (.clk(clk), .rst_b(rst_b), .req(req), .rdata(rdata),
        .stop_req(stop_req), .kr_ack(kr_ack), .wt_ack(wt_ack), .key_n(key_n),
        .sub_xtal_in(xin), .sub_xtal_out(xout), .sub_xtal_out_oe(xoe), .cpu_run(cpu_run),
        .main_clk_run(main_run), .sub_osc_run(sub_run), .ls_osc_run(ls_run),
        .key_return_irq(kirq), .watch_tick_irq(wirq));
    swc_far_model far (.clk(clk), .xtal_oe(xoe), .sub_xtal_in(xin), .key_n(key_n));

    // ----
    // Shared tasks
    // ----
    task automatic close_out();
        $display("Checks %0d, mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : close_out

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        req.addr  <= a;
        req.wdata <= d;
        req.wr    <= 1'b1;
        @(posedge clk);
        req.wr <= 1'b0;
    endtask : wr

    // Read data stand only in the cycle after the strobe
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        req.addr <= a;
        req.rd   <= 1'b1;
        @(posedge clk);
        req.rd <= 1'b0;
        #1;
        chk(rdata, exp);
    endtask : rd_chk

    task automatic stop_pulse();
        @(posedge clk);
        stop_req <= 1'b1;
        @(posedge clk);
        stop_req <= 1'b0;
        #1;
    endtask : stop_pulse

    // Press a key in stop, time the wake, then acknowledge
    task automatic wake_by(input int key);
        int n;
        n = 0;
        far.set_key(key, 1'b0);
        while (main_run !== 1'b1 && n < 20)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        chk({30'h0, main_run, kirq}, 32'h3);
        n = 0;
        while (cpu_run !== 1'b1 && n < 100)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        chk(n, STAB);
        chk({31'h0, kirq}, 32'h1);
        @(posedge clk);
        kr_ack <= 1'b1;
        wt_ack <= 1'b1;
        @(posedge clk);
        kr_ack <= 1'b0;
        wt_ack <= 1'b0;
        #1;
        chk({30'h0, kirq, wirq}, 32'h0);
        far.set_key(key, 1'b1);
    endtask : wake_by

    // ----
    // Scenarios
    // ----
    task automatic t_reset();
        chk({28'h0, cpu_run, main_run, sub_run, ls_run}, 32'hF);
        chk({30'h0, xoe, xout ^ xin}, 32'h3);
        rd_chk(`SWC_OFS_OSC_PIN, 32'h1);
        rd_chk(`SWC_OFS_INT_OSC, 32'h0);
        rd_chk(`SWC_OFS_CLK_CTRL, 32'h1);
        rd_chk(`SWC_OFS_KEY_EN, 32'h1F);
        rd_chk(8'h14, 32'h0);
        $display("Test reset done");
    endtask : t_reset

    task automatic t_interval();
        repeat (76000) @(posedge clk);
        rd_chk(`SWC_OFS_STATUS, 32'hC0);
        repeat (4000) @(posedge clk);
        rd_chk(`SWC_OFS_STATUS, 32'hC4);
        wr(`SWC_OFS_STATUS, 32'h4);
        rd_chk(`SWC_OFS_STATUS, 32'hC0);
        $display("Test interval done");
    endtask : t_interval

    task automatic t_refuse();
        wr(`SWC_OFS_CLK_CTRL, 32'h3);
        stop_pulse();
        chk({30'h0, cpu_run, main_run}, 32'h3);
        rd_chk(`SWC_OFS_STATUS, 32'hC8);
        wr(`SWC_OFS_CLK_CTRL, 32'h1);
        $display("Test refuse done");
    endtask : t_refuse

    task automatic t_stop_key();
        stop_pulse();
        chk({29'h0, cpu_run, main_run, sub_run}, 32'h1);
        rd_chk(`SWC_OFS_STATUS, 32'hC3);
        wake_by(0);
        $display("Test stop key done");
    endtask : t_stop_key

    task automatic t_stop_all();
        wr(`SWC_OFS_CLK_CTRL, 32'h0);
        wr(`SWC_OFS_OSC_PIN, 32'h0);
        wr(`SWC_OFS_INT_OSC, 32'h1);
        @(posedge clk);
        #1;
        chk({28'h0, sub_run, xoe, xout, ls_run}, 32'h0);
        stop_pulse();
        chk({28'h0, cpu_run, main_run, sub_run, ls_run}, 32'h0);
        far.set_key(5, 1'b0);
        repeat (40) @(posedge clk);
        #1;
        chk({29'h0, main_run, kirq, wirq}, 32'h0);
        wake_by(2);
        far.set_key(5, 1'b1);
        wr(`SWC_OFS_OSC_PIN, 32'h1);
        wr(`SWC_OFS_INT_OSC, 32'h0);
        wr(`SWC_OFS_CLK_CTRL, 32'h1);
        @(posedge clk);
        #1;
        chk({30'h0, sub_run, ls_run}, 32'h3);
        $display("Test stop all done");
    endtask : t_stop_all

    // Hang guard
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 95000)
        begin
            miscompares++;
            close_out();
        end
    end

    initial
    begin
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        t_reset();
        t_interval();
        t_refuse();
        t_stop_key();
        t_stop_all();
        close_out();
    end
endmodule : tb

//--- core/swc_defs.svh
// Constants for the stop-mode clock and wake controller
// Functional notes
// - Stop refused while CPU runs on subclock
// - Stop halts CPU, stops main clock
// - Key or watch interrupt cancels stop
// - Wake services interrupt, then resumes execution
// - Watch timer interrupt every half second
// - Stopped watch timer gives no interrupt
// - Pin-select zero stops subclock crystal
// - Low-speed halt bit stops low-speed oscillator
// - Both stopped means no clock in stop
// - Falling edge on enabled key raises interrupt
// - Interval counter flags every 1953 microseconds
`ifndef SWC_DEFS_SVH
`define SWC_DEFS_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses, one word each)
// ----------------------------------------------------------------
`define SWC_OFS_OSC_PIN   8'h00
`define SWC_OFS_INT_OSC   8'h04
`define SWC_OFS_CLK_CTRL  8'h08
`define SWC_OFS_KEY_EN    8'h0C
`define SWC_OFS_STATUS    8'h10

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SWC_BIT_PIN_SEL    0
`define SWC_BIT_LS_HALT    0
`define SWC_BIT_WT_EN      0
`define SWC_BIT_CPU_SUB    1
`define SWC_ST_STOPPED     0
`define SWC_ST_CPU_HOLD    1
`define SWC_ST_IVL_FLAG    2
`define SWC_ST_REFUSED     3
`define SWC_ST_KR_PEND     4
`define SWC_ST_WT_PEND     5
`define SWC_ST_SUB_RUN     6
`define SWC_ST_LS_RUN      7

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define SWC_RST_PIN_SEL  1'b1
`define SWC_RST_LS_HALT  1'b0
`define SWC_RST_WT_EN    1'b1
`define SWC_RST_CPU_SUB  1'b0
`define SWC_RST_KEY_EN   8'h1F

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SWC_CLK_HZ        40000000
`define SWC_SUB_HZ        32768
`define SWC_SUB_DIV       (`SWC_CLK_HZ / `SWC_SUB_HZ)
`define SWC_WT_HALF_US    500000
`define SWC_WT_HALF_TICKS (64'd`SWC_WT_HALF_US * 64'd`SWC_SUB_HZ / 64'd1000000)
`define SWC_IVL_US        1953
`define SWC_IVL_TICKS     ((64'd`SWC_IVL_US * 64'd`SWC_SUB_HZ + 64'd999999) / 64'd1000000)
`define SWC_STAB_US       8200
`define SWC_STAB_CYC      (64'd`SWC_STAB_US * 64'd`SWC_CLK_HZ / 64'd1000000)
`define SWC_KEY_W         8

`endif

//--- core/swc_key_edge.sv
// Falling-edge detector for the key-return inputs
`timescale 1ns/1ps
`include "swc_defs.svh"
module swc_key_edge (
    input  wire logic                  clk,
    input  wire logic                  rst_b,
    input  wire logic [`SWC_KEY_W-1:0] key_n,
    input  wire logic [`SWC_KEY_W-1:0] key_en,
    output logic                       fall
);
    logic [`SWC_KEY_W-1:0] prev_q;   // Key levels one cycle ago
    logic [`SWC_KEY_W-1:0] prev_d;
    logic                  fall_d;

    // ------------------------------------------------------------
    // Edge compare; keys idle high, a press pulls a pin low
    // ------------------------------------------------------------
    always_comb
    begin
        prev_d = key_n;
        fall_d = |(prev_q & ~key_n & key_en);
    end

    // ------------------------------------------------------------
    // Registers; reset to idle high, so a key held low through reset gives an edge
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            prev_q <= {`SWC_KEY_W{1'b1}};
            fall   <= 1'b0;
        end
        else
        begin
            prev_q <= prev_d;
            fall   <= fall_d;
        end
    end
endmodule : swc_key_edge

//--- core/swc_pkg.sv
// Types shared by the stop-mode clock and wake controller
package swc_pkg;

    // Power state of the CPU clock domain
    typedef enum logic [1:0]
    {
        SWC_RUN,
        SWC_STOP,
        SWC_STAB
    } swc_state_e;

    // Register port request from software
    typedef struct packed
    {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } swc_req_s;

endpackage : swc_pkg

//--- core/swc_tick_div.sv
// Enabled modulo counter giving a one-cycle tick every DIV enables
`timescale 1ns/1ps
module swc_tick_div #(
    parameter int unsigned DIV = 2
) (
    input  wire logic clk,
    input  wire logic rst_b,
    input  wire logic en,
    input  wire logic clr,
    output logic      tick
);
    localparam int unsigned W = (DIV > 1) ? $clog2(DIV) : 1;

    logic [W-1:0] cnt_q;    // Current count
    logic [W-1:0] cnt_d;    // Next count
    logic         tick_d;   // Wrap in this cycle

    // ------------------------------------------------------------
    // Next count
    // ------------------------------------------------------------
    always_comb
    begin
        cnt_d  = cnt_q;
        tick_d = 1'b0;
        if (clr)
        begin
            cnt_d = '0;   // Restart keeps the first period whole
        end
        else if (en)
        begin
            if (cnt_q == W'(DIV - 1))
            begin
                cnt_d  = '0;
                tick_d = 1'b1;
            end
            else
            begin
                cnt_d = cnt_q + 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cnt_q <= '0;
            tick  <= 1'b0;
        end
        else
        begin
            cnt_q <= cnt_d;
            tick  <= tick_d;
        end
    end
endmodule : swc_tick_div

//--- core/swc_top.sv
// Stop-mode entry, clock gating and wake control
`timescale 1ns/1ps
`include "swc_defs.svh"
module swc_top #(
    parameter int unsigned STAB_CYC = int'(`SWC_STAB_CYC)
) (
    input  wire logic                  clk,
    input  wire logic                  rst_b,
    input  swc_pkg::swc_req_s          req,
    output logic [31:0]                rdata,
    input  wire logic                  stop_req,
    input  wire logic                  kr_ack,
    input  wire logic                  wt_ack,
    input  wire logic [`SWC_KEY_W-1:0] key_n,
    input  wire logic                  sub_xtal_in,
    output logic                       sub_xtal_out,
    output logic                       sub_xtal_out_oe,
    output logic                       cpu_run,
    output logic                       main_clk_run,
    output logic                       sub_osc_run,
    output logic                       ls_osc_run,
    output logic                       key_return_irq,
    output logic                       watch_tick_irq
);
    import swc_pkg::*;

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    localparam int unsigned SUB_DIV  = int'(`SWC_SUB_DIV);
    localparam int unsigned HALF_DIV = int'(`SWC_WT_HALF_TICKS);
    localparam int unsigned IVL_DIV  = int'(`SWC_IVL_TICKS);

    swc_state_e            st_q, st_d;             // Power state
    logic [31:0]           stab_q, stab_d;         // Stabilisation count
    logic                  pin_sel_q, pin_sel_d;   // Crystal pins in osc mode
    logic                  ls_halt_q, ls_halt_d;   // Low-speed osc halted
    logic                  wt_en_q, wt_en_d;       // Watch timer enabled
    logic                  cpu_sub_q, cpu_sub_d;   // CPU clocked by subclock
    logic [`SWC_KEY_W-1:0] key_en_q, key_en_d;     // Key-return enables
    logic                  ivl_q, ivl_d;           // Interval flag
    logic                  refused_q, refused_d;   // Last stop refused
    logic                  kr_q, kr_d;             // Key-return pending
    logic                  wt_q, wt_d;             // Watch tick pending
    logic [31:0]           rdata_d;                // Read data next
    logic                  sub_tick;               // Subclock edge enable
    logic                  half_tick;              // Half-second tick
    logic                  ivl_tick;               // Interval overflow
    logic                  key_fall;               // Key press edge
    logic                  wt_run;                 // Watch timer counting
    logic                  wake;                   // Stop-cancel event
    logic [31:0]           status;                 // Status word

    // Writes decoded per register
    logic wr_pin, wr_ls, wr_ctl, wr_key, wr_st;

    assign wr_pin = req.wr && (req.addr == `SWC_OFS_OSC_PIN);
    assign wr_ls  = req.wr && (req.addr == `SWC_OFS_INT_OSC);
    assign wr_ctl = req.wr && (req.addr == `SWC_OFS_CLK_CTRL);
    assign wr_key = req.wr && (req.addr == `SWC_OFS_KEY_EN);
    assign wr_st  = req.wr && (req.addr == `SWC_OFS_STATUS);

    // ------------------------------------------------------------
    // Oscillators and pins
    // ------------------------------------------------------------
    // The crystal amplifier only drives while the pins are in
    // oscillator mode; in port mode the crystal loses its loop gain.
    assign sub_osc_run     = pin_sel_q;
    assign sub_xtal_out_oe = pin_sel_q;
    assign sub_xtal_out    = pin_sel_q & ~sub_xtal_in;
    assign ls_osc_run      = ~ls_halt_q;
    // In stop the main clock is off; with both slow oscillators
    // also off nothing toggles at all.
    assign main_clk_run    = (st_q != SWC_STOP);
    assign cpu_run         = (st_q == SWC_RUN);
    assign wt_run          = wt_en_q & sub_osc_run;

    // Subclock edge enable, present only while the crystal runs
    swc_tick_div #(
        .DIV (SUB_DIV)
    ) u_sub_div (
        .clk   (clk),
        .rst_b (rst_b),
        .en    (sub_osc_run),
        .clr   (~sub_osc_run),
        .tick  (sub_tick)
    );

    // Watch timer: half-second period on subclock edges
    swc_tick_div #(
        .DIV (HALF_DIV)
    ) u_half_div (
        .clk   (clk),
        .rst_b (rst_b),
        .en    (wt_run & sub_tick),
        .clr   (~wt_run),
        .tick  (half_tick)
    );

    // Interval counter: overflow every 1953 us of subclock
    swc_tick_div #(
        .DIV (IVL_DIV)
    ) u_ivl_div (
        .clk   (clk),
        .rst_b (rst_b),
        .en    (sub_osc_run & sub_tick),
        .clr   (~sub_osc_run),
        .tick  (ivl_tick)
    );

    // Key-return falling edges; works in stop as well
    swc_key_edge u_key (
        .clk    (clk),
        .rst_b  (rst_b),
        .key_n  (key_n),
        .key_en (key_en_q),
        .fall   (key_fall)
    );

    assign wake = key_fall | half_tick;

    // ------------------------------------------------------------
    // Power state machine
    // ------------------------------------------------------------
    always_comb
    begin
        st_d      = st_q;
        stab_d    = stab_q;
        refused_d = refused_q;
        case (st_q)
            SWC_RUN:
            begin
                if (stop_req)
                begin
                    if (cpu_sub_q)
                    begin
                        refused_d = 1'b1;
                    end
                    else
                    begin
                        refused_d = 1'b0;
                        st_d      = SWC_STOP;
                    end
                end
            end
            SWC_STOP:
            begin
                if (wake)
                begin
                    st_d   = SWC_STAB;
                    stab_d = '0;
                end
            end
            SWC_STAB:
            begin
                // CPU stays held while the oscillator settles
                if (stab_q >= STAB_CYC - 1)
                begin
                    st_d = SWC_RUN;
                end
                else
                begin
                    stab_d = stab_q + 32'h1;
                end
            end
            default:
            begin
                st_d = SWC_RUN;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            st_q      <= SWC_RUN;
            stab_q    <= 32'h0;
            refused_q <= 1'b0;
        end
        else
        begin
            st_q      <= st_d;
            stab_q    <= stab_d;
            refused_q <= refused_d;
        end
    end

    // ------------------------------------------------------------
    // Interrupt pending flags and interval flag
    // ------------------------------------------------------------
    // Pending flags stay up through the stabilisation wait, so the
    // CPU takes the waking interrupt first when it resumes. A new
    // event in the clearing cycle wins over the clear.
    always_comb
    begin
        kr_d  = key_fall | (kr_q & ~kr_ack);
        wt_d  = half_tick | (wt_q & ~wt_ack);
        ivl_d = ivl_tick | (ivl_q & ~(wr_st & req.wdata[`SWC_ST_IVL_FLAG]));
    end

    assign key_return_irq = kr_q;
    assign watch_tick_irq = wt_q;

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            kr_q  <= 1'b0;
            wt_q  <= 1'b0;
            ivl_q <= 1'b0;
        end
        else
        begin
            kr_q  <= kr_d;
            wt_q  <= wt_d;
            ivl_q <= ivl_d;
        end
    end

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    always_comb
    begin
        pin_sel_d = pin_sel_q;
        ls_halt_d = ls_halt_q;
        wt_en_d   = wt_en_q;
        cpu_sub_d = cpu_sub_q;
        key_en_d  = key_en_q;
        if (wr_pin)
        begin
            pin_sel_d = req.wdata[`SWC_BIT_PIN_SEL];
        end
        if (wr_ls)
        begin
            ls_halt_d = req.wdata[`SWC_BIT_LS_HALT];
        end
        if (wr_ctl)
        begin
            wt_en_d   = req.wdata[`SWC_BIT_WT_EN];
            cpu_sub_d = req.wdata[`SWC_BIT_CPU_SUB];
        end
        if (wr_key)
        begin
            key_en_d = req.wdata[`SWC_KEY_W-1:0];
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pin_sel_q <= `SWC_RST_PIN_SEL;
            ls_halt_q <= `SWC_RST_LS_HALT;
            wt_en_q   <= `SWC_RST_WT_EN;
            cpu_sub_q <= `SWC_RST_CPU_SUB;
            key_en_q  <= `SWC_RST_KEY_EN;
        end
        else
        begin
            pin_sel_q <= pin_sel_d;
            ls_halt_q <= ls_halt_d;
            wt_en_q   <= wt_en_d;
            cpu_sub_q <= cpu_sub_d;
            key_en_q  <= key_en_d;
        end
    end

    // ------------------------------------------------------------
    // Read path: data stand one cycle after the strobe only
    // ------------------------------------------------------------
    always_comb
    begin
        status                     = 32'h0;
        status[`SWC_ST_STOPPED]    = (st_q == SWC_STOP);
        status[`SWC_ST_CPU_HOLD]   = (st_q != SWC_RUN);
        status[`SWC_ST_IVL_FLAG]   = ivl_q;
        status[`SWC_ST_REFUSED]    = refused_q;
        status[`SWC_ST_KR_PEND]    = kr_q;
        status[`SWC_ST_WT_PEND]    = wt_q;
        status[`SWC_ST_SUB_RUN]    = sub_osc_run;
        status[`SWC_ST_LS_RUN]     = ls_osc_run;
        rdata_d = 32'h0;
        if (req.rd)
        begin
            case (req.addr)
                `SWC_OFS_OSC_PIN:  rdata_d = {31'h0, pin_sel_q};
                `SWC_OFS_INT_OSC:  rdata_d = {31'h0, ls_halt_q};
                `SWC_OFS_CLK_CTRL: rdata_d = {30'h0, cpu_sub_q, wt_en_q};
                `SWC_OFS_KEY_EN:   rdata_d = {24'h0, key_en_q};
                `SWC_OFS_STATUS:   rdata_d = status;
                default:           rdata_d = 32'h0;   // Unmapped reads zero
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rdata <= 32'h0;
        end
        else
        begin
            rdata <= rdata_d;
        end
    end
endmodule : swc_top
